/* File: src/ssfc_pkg.sv */
// Offsets, field positions, reset values and carrier types of the slot status register bank
package ssfc_pkg;
  localparam int unsigned AW = 12;
  localparam int unsigned DW = 32;
  // Register indices; byte address is four times the index
  localparam logic [AW-1:0] IDX_SLOT_CTRL  = 12'h058;
  localparam logic [AW-1:0] IDX_SLOT_STAT  = 12'h05a;
  localparam logic [AW-1:0] IDX_DEV_CAP2   = 12'h064;
  localparam logic [AW-1:0] IDX_DEV_CTL2   = 12'h068;
  localparam logic [AW-1:0] IDX_DEV_STS2   = 12'h06a;
  localparam logic [AW-1:0] IDX_IRQ_MASK   = 12'h0c0;
  // Slot status fields
  localparam int unsigned B_ATTN     = 0;
  localparam int unsigned B_PFAULT   = 1;
  localparam int unsigned B_LATCH_CH = 2;
  localparam int unsigned B_PRES_CH  = 3;
  localparam int unsigned B_CMD_DONE = 4;
  localparam int unsigned B_LATCH    = 5;
  localparam int unsigned B_PRESENT  = 6;
  localparam int unsigned B_ILOCK    = 7;
  localparam int unsigned B_LINK_CH  = 8;
  localparam logic [15:0] STAT_FLAGS = 16'h011f;
  // Slot control enable fields
  localparam int unsigned B_HP_IE    = 5;
  localparam int unsigned B_LINK_CE  = 12;
  localparam logic [15:0] CTRL_MASK  = 16'h103f;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Forwarding fields
  localparam int unsigned B_FWD      = 5;
  // Reset values of the live state bits
  localparam logic RST_LATCH    = 1'b0;
  localparam logic RST_PRESENT  = 1'b1;
  localparam logic RST_ILOCK    = 1'b0;
  localparam logic RST_LINK     = 1'b0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;

  // One-cycle event strobes from the slot side
  typedef struct packed {
    logic attn_press;
    logic power_fault;
    logic cmd_actions_done;
  } ssfc_evt_s;

  // Live levels from the slot side
  typedef struct packed {
    logic latch_open;
    logic card_present;
    logic interlock_engaged;
    logic link_active;
  } ssfc_lvl_s;
endpackage

/* File: src/ssfc_regs.sv */
// Slot status and forwarding control register bank on an APB slave
`timescale 1ns/10ps
// Operation
// - Attention press sets status bit 0
// - Power fault sets status bit 1
// - Latch sensor change sets bit 2
// - Presence change sets bit 3
// - Command finish sets sticky bit 4
// - Each slot control write is one command
// - Bit 4 waits for all command actions
// - Bit 5 shows latch state, reset 0
// - Bit 6 shows card presence, reset 1
// - Bit 7 shows interlock engaged state
// - Link active toggle sets bit 8
// - Forwarding supported reads 1 downstream only
// - Unsupported forwarding forces enable to zero
// - Enable stops device-zero forcing downstream
// - Upstream enable reads zero, ignores writes
// - Event interrupt needs its enable bit
// - Command interrupt needs its enable bit
module ssfc_regs (
  input  wire logic              CLK_SYS,
  input  wire logic              RESETN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic                   PREADY,
  output logic [31:0]            PRDATA,
  output logic                   PSLVERR,
  input  wire logic              IS_UPSTREAM,
  input  wire ssfc_pkg::ssfc_evt_s SLOT_EVT,
  input  wire ssfc_pkg::ssfc_lvl_s SLOT_LVL,
  output logic [15:0]            SLOT_CTRL,
  output logic                   CMD_ISSUE,
  output logic                   CMD_BUSY,
  output logic                   FWD_ENABLE,
  output logic                   FORCE_DEV_ZERO,
  output logic                   IRQ
);

  logic        rst_meta;
  logic        rst_n;
  logic        upstream;
  logic        access;
  logic        wr_en;
  logic [15:0] ctrl;
  logic [15:0] flags;
  logic [15:0] mask;
  logic [15:0] next_flags;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] stat_word;
  logic        latch;
  logic        present;
  logic        ilock;
  logic        link;
  logic        fwd_en;
  logic        cmd_pend;
  logic [31:0] next_rdata;
  logic        mapped;
  logic [15:0] irq_en;

  // Byte address of a register index
  function automatic logic [11:0] baddr(input logic [11:0] idx);
    baddr = {idx[9:0], 2'b00};
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
    hit = (a == baddr(idx));
  endfunction

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] set,
                                      input logic [15:0] clr);
    w1c = set | (cur & ~clr);
  endfunction

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Port role, sampled from IS_UPSTREAM every cycle after reset release
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      upstream <= 1'b0;
    end else begin
      upstream <= IS_UPSTREAM;
    end
  end

  assign access = PSEL && PENABLE && !PREADY;
  // Writes land at the edge where the master sees ready high
  assign wr_en  = PSEL && PENABLE && PREADY && PWRITE;

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PRDATA  <= ssfc_pkg::ZERO_WORD;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access;
      PRDATA  <= (access && !PWRITE) ? next_rdata : ssfc_pkg::ZERO_WORD;
      PSLVERR <= access && !mapped;
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_ctl2;
  logic wr_mask;
  assign wr_ctrl = wr_en && hit(PADDR, ssfc_pkg::IDX_SLOT_CTRL);
  assign wr_stat = wr_en && hit(PADDR, ssfc_pkg::IDX_SLOT_STAT);
  assign wr_ctl2 = wr_en && hit(PADDR, ssfc_pkg::IDX_DEV_CTL2);
  assign wr_mask = wr_en && hit(PADDR, ssfc_pkg::IDX_IRQ_MASK);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ssfc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      if (PSTRB[0]) ctrl[7:0]  <= PWDATA[7:0] & ssfc_pkg::CTRL_MASK[7:0];
      if (PSTRB[1]) ctrl[15:8] <= PWDATA[15:8] & ssfc_pkg::CTRL_MASK[15:8];
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mask <= ssfc_pkg::MASK_RESET;
    end else if (wr_mask) begin
      if (PSTRB[0]) mask[7:0]  <= PWDATA[7:0] & ssfc_pkg::STAT_FLAGS[7:0];
      if (PSTRB[1]) mask[15:8] <= PWDATA[15:8] & ssfc_pkg::STAT_FLAGS[15:8];
    end
  end

  // Command tracking: each slot control write issues one command
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CMD_ISSUE <= 1'b0;
      cmd_pend  <= 1'b0;
    end else begin
      CMD_ISSUE <= wr_ctrl;
      if (wr_ctrl) begin
        cmd_pend <= 1'b1;
      end else if (SLOT_EVT.cmd_actions_done) begin
        cmd_pend <= 1'b0;
      end
    end
  end

  // Live slot levels
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      latch   <= ssfc_pkg::RST_LATCH;
      present <= ssfc_pkg::RST_PRESENT;
      ilock   <= ssfc_pkg::RST_ILOCK;
      link    <= ssfc_pkg::RST_LINK;
    end else begin
      latch   <= SLOT_LVL.latch_open;
      present <= SLOT_LVL.card_present;
      ilock   <= SLOT_LVL.interlock_engaged;
      link    <= SLOT_LVL.link_active;
    end
  end

  always_comb begin
    set_vec = 16'h0000;
    set_vec[ssfc_pkg::B_ATTN]     = SLOT_EVT.attn_press;
    set_vec[ssfc_pkg::B_PFAULT]   = SLOT_EVT.power_fault;
    set_vec[ssfc_pkg::B_LATCH_CH] = SLOT_LVL.latch_open ^ latch;
    set_vec[ssfc_pkg::B_PRES_CH]  = SLOT_LVL.card_present ^ present;
    set_vec[ssfc_pkg::B_CMD_DONE] = cmd_pend && !wr_ctrl && SLOT_EVT.cmd_actions_done;
    set_vec[ssfc_pkg::B_LINK_CH]  = SLOT_LVL.link_active ^ link;
  end

  always_comb begin
    clr_vec = 16'h0000;
    if (wr_stat) begin
      if (PSTRB[0]) clr_vec[7:0]  = PWDATA[7:0];
      if (PSTRB[1]) clr_vec[15:8] = PWDATA[15:8];
    end
    clr_vec = clr_vec & ssfc_pkg::STAT_FLAGS;
  end

  assign next_flags = w1c(flags, set_vec, clr_vec);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 16'h0000;
    end else begin
      flags <= next_flags & ssfc_pkg::STAT_FLAGS;
    end
  end

  always_comb begin
    stat_word = flags;
    stat_word[ssfc_pkg::B_LATCH]   = latch;
    stat_word[ssfc_pkg::B_PRESENT] = present;
    stat_word[ssfc_pkg::B_ILOCK]   = ilock;
  end

  // Forwarding enable, writable only where supported
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      fwd_en <= 1'b0;
    end else if (upstream) begin
      fwd_en <= 1'b0;
    end else if (wr_ctl2 && PSTRB[0]) begin
      fwd_en <= PWDATA[ssfc_pkg::B_FWD];
    end
  end

  always_comb begin
    next_rdata = ssfc_pkg::ZERO_WORD;
    mapped     = 1'b1;
    if (hit(PADDR, ssfc_pkg::IDX_SLOT_CTRL)) begin
      next_rdata[15:0] = ctrl;
    end else if (hit(PADDR, ssfc_pkg::IDX_SLOT_STAT)) begin
      next_rdata[15:0] = stat_word;
    end else if (hit(PADDR, ssfc_pkg::IDX_DEV_CAP2)) begin
      next_rdata[ssfc_pkg::B_FWD] = !upstream;
    end else if (hit(PADDR, ssfc_pkg::IDX_DEV_CTL2)) begin
      next_rdata[ssfc_pkg::B_FWD] = fwd_en && !upstream;
    end else if (hit(PADDR, ssfc_pkg::IDX_DEV_STS2)) begin
      next_rdata = ssfc_pkg::ZERO_WORD;
    end else if (hit(PADDR, ssfc_pkg::IDX_IRQ_MASK)) begin
      next_rdata[15:0] = mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // Per-event interrupt enables; events also need the master enable
  always_comb begin
    irq_en = 16'h0000;
    irq_en[ssfc_pkg::B_CMD_DONE:0] = ctrl[ssfc_pkg::B_CMD_DONE:0];
    irq_en[ssfc_pkg::B_LINK_CH] = ctrl[ssfc_pkg::B_LINK_CE];
    if (!ctrl[ssfc_pkg::B_HP_IE]) irq_en = 16'h0000;
  end

  logic [15:0] irq_en_full;
  always_comb begin
    irq_en_full = irq_en;
    irq_en_full[ssfc_pkg::B_PFAULT:0] = ctrl[ssfc_pkg::B_PFAULT:0] & {2{ctrl[ssfc_pkg::B_HP_IE]}};
    irq_en_full[ssfc_pkg::B_CMD_DONE:ssfc_pkg::B_LATCH_CH] =
      ctrl[ssfc_pkg::B_CMD_DONE:ssfc_pkg::B_LATCH_CH] & {3{ctrl[ssfc_pkg::B_HP_IE]}};
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      IRQ            <= 1'b0;
      SLOT_CTRL      <= ssfc_pkg::CTRL_RESET;
      CMD_BUSY       <= 1'b0;
      FWD_ENABLE     <= 1'b0;
      FORCE_DEV_ZERO <= 1'b1;
    end else begin
      IRQ            <= |(next_flags & ssfc_pkg::STAT_FLAGS & mask & irq_en_full);
      SLOT_CTRL      <= ctrl;
      CMD_BUSY       <= cmd_pend;
      FWD_ENABLE     <= fwd_en && !upstream;
      FORCE_DEV_ZERO <= !(fwd_en && !upstream);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  property p_attn;
    SLOT_EVT.attn_press |=> flags[ssfc_pkg::B_ATTN];
  endproperty
  a_attn: assert property (p_attn) else $error("attention flag not set");

  property p_pfault;
    SLOT_EVT.power_fault |=> flags[ssfc_pkg::B_PFAULT];
  endproperty
  a_pfault: assert property (p_pfault) else $error("power fault flag not set");

  property p_latch_ch;
    (SLOT_LVL.latch_open != latch) |=> flags[ssfc_pkg::B_LATCH_CH] && latch == $past(SLOT_LVL.latch_open);
  endproperty
  a_latch_ch: assert property (p_latch_ch) else $error("latch change lost");

  property p_pres_ch;
    $changed(present) |-> flags[ssfc_pkg::B_PRES_CH];
  endproperty
  a_pres_ch: assert property (p_pres_ch) else $error("presence change lost");

  property p_cc_sticky;
    flags[ssfc_pkg::B_CMD_DONE] && !clr_vec[ssfc_pkg::B_CMD_DONE] |=> flags[ssfc_pkg::B_CMD_DONE];
  endproperty
  a_cc_sticky: assert property (p_cc_sticky) else $error("command flag dropped");

  property p_cc_wait;
    $rose(flags[ssfc_pkg::B_CMD_DONE]) |-> $past(SLOT_EVT.cmd_actions_done) && $past(cmd_pend);
  endproperty
  a_cc_wait: assert property (p_cc_wait) else $error("command flag early");

  property p_issue;
    wr_ctrl |=> CMD_ISSUE ##1 (!CMD_ISSUE || $past(wr_ctrl));
  endproperty
  a_issue: assert property (p_issue) else $error("command issue not one pulse");

  property p_link_ch;
    $changed(link) |-> flags[ssfc_pkg::B_LINK_CH];
  endproperty
  a_link_ch: assert property (p_link_ch) else $error("link change lost");

  property p_up_fwd;
    upstream |=> !FWD_ENABLE && FORCE_DEV_ZERO;
  endproperty
  a_up_fwd: assert property (p_up_fwd) else $error("upstream forwarding enabled");

  property p_w1c;
    clr_vec[ssfc_pkg::B_ATTN] && !set_vec[ssfc_pkg::B_ATTN] |=> !flags[ssfc_pkg::B_ATTN];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_irq_gate;
    IRQ |-> $past(ctrl[ssfc_pkg::B_HP_IE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

  property p_present_live;
    1'b1 |=> present == $past(SLOT_LVL.card_present);
  endproperty
  a_present_live: assert property (p_present_live) else $error("presence bit stale");

  property p_ilock_live;
    1'b1 |=> ilock == $past(SLOT_LVL.interlock_engaged);
  endproperty
  a_ilock_live: assert property (p_ilock_live) else $error("interlock bit stale");

  property p_reserved;
    stat_word[15:9] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");

  property p_cap_up;
    upstream && hit(PADDR, ssfc_pkg::IDX_DEV_CAP2) |-> next_rdata == ssfc_pkg::ZERO_WORD;
  endproperty
  a_cap_up: assert property (p_cap_up) else $error("upstream claims forwarding");

  property p_up_fwd_reg;
    upstream |=> !fwd_en;
  endproperty
  a_up_fwd_reg: assert property (p_up_fwd_reg) else $error("upstream enable kept");

  property p_force_dev;
    FORCE_DEV_ZERO == !FWD_ENABLE;
  endproperty
  a_force_dev: assert property (p_force_dev) else $error("device zero forcing wrong");

  property p_issue_once;
    CMD_ISSUE |=> !CMD_ISSUE;
  endproperty
  a_issue_once: assert property (p_issue_once) else $error("command issued twice");

  property p_pfault_sticky;
    flags[ssfc_pkg::B_PFAULT] && !clr_vec[ssfc_pkg::B_PFAULT] |=> flags[ssfc_pkg::B_PFAULT];
  endproperty
  a_pfault_sticky: assert property (p_pfault_sticky) else $error("power fault flag dropped");

endmodule

/* File: tb/ssfc_slot_model.sv */
// Behavioural slot sensors and expander behind the register bank
`timescale 1ns/10ps
module ssfc_slot_model (
  input  wire logic                clk,
  input  wire logic                cmd_issue,
  input  wire logic [7:0]          done_delay,
  input  wire logic [1:0]          evt_req,
  input  wire ssfc_pkg::ssfc_lvl_s lvl_req,
  output ssfc_pkg::ssfc_evt_s      evt,
  output ssfc_pkg::ssfc_lvl_s      lvl
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    evt = '0;
    lvl = 4'h4;
  end
  // Expander work lasts done_delay cycles after each command
  always @(posedge clk) begin
    evt.attn_press       <= evt_req[0];
    evt.power_fault      <= evt_req[1];
    lvl                  <= lvl_req;
    evt.cmd_actions_done <= (cnt == 8'h01);
    if (cmd_issue) begin
      cnt <= done_delay;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the slot status register bank
`timescale 1ns/10ps
module tb_top;
  logic                clk_sys = 1'b0;
  logic                resetn  = 1'b0;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic                is_upstream = 1'b0;
  logic [11:0]         paddr   = 12'h000;
  logic [31:0]         pwdata  = 32'h0;
  logic [31:0]         prdata;
  logic                pready, pslverr, cmd_issue, cmd_busy, fwd_enable, force_dev_zero, irq;
  logic [15:0]         slot_ctrl;
  logic [7:0]          delay   = 8'h01;
  logic [1:0]          evt_req = 2'h0;
  ssfc_pkg::ssfc_lvl_s lvl_req = 4'h4;
  ssfc_pkg::ssfc_lvl_s lvl;
  ssfc_pkg::ssfc_evt_s evt;
  logic [15:0]         flags = 16'h0, mask = 16'h0, ctrl = 16'h0, rnd = 16'd28438;
  logic [31:0]         rd;
  logic                err;
  int                  bad_count = 0, checked = 0, issues = 0, n0;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cmd_issue === 1'b1) issues++;

  ssfc_regs u_ssfc_regs (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'h3), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .IS_UPSTREAM(is_upstream), .SLOT_EVT(evt), .SLOT_LVL(lvl), .SLOT_CTRL(slot_ctrl), .CMD_ISSUE(cmd_issue),
    .CMD_BUSY(cmd_busy), .FWD_ENABLE(fwd_enable), .FORCE_DEV_ZERO(force_dev_zero), .IRQ(irq));
  ssfc_slot_model u_ssfc_slot_model (.clk(clk_sys), .cmd_issue(cmd_issue), .done_delay(delay),
    .evt_req(evt_req), .lvl_req(lvl_req), .evt(evt), .lvl(lvl));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] exp_stat();
    return {16'h0, flags | {8'h0, lvl_req.interlock_engaged, lvl_req.card_present, lvl_req.latch_open, 5'h0}};
  endfunction
  function automatic logic exp_irq();
    return ctrl[5] & (|(flags & mask & {7'h0, ctrl[12], 3'h0, ctrl[4:0]}));
  endfunction

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx[9:0], 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk_word(rd, exp);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys);
    evt_req[b] <= 1'b1;
    @(posedge clk_sys);
    evt_req[b] <= 1'b0;
    flags[b] = 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic lvl_set(input ssfc_pkg::ssfc_lvl_s v);
    flags[2] = flags[2] | (v.latch_open ^ lvl_req.latch_open);
    flags[3] = flags[3] | (v.card_present ^ lvl_req.card_present);
    flags[8] = flags[8] | (v.link_active ^ lvl_req.link_active);
    @(posedge clk_sys);
    lvl_req <= v;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(ssfc_pkg::IDX_SLOT_STAT, 32'h40);
    rdc(ssfc_pkg::IDX_DEV_CAP2, 32'h20);
    rdc(ssfc_pkg::IDX_DEV_STS2, 32'h0);
    rdc(12'h001, 32'h0);
    chk_pin(err, 1'b1);
    pulse(0);
    pulse(1);
    lvl_set(4'hb);
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    apb(1'b1, ssfc_pkg::IDX_SLOT_STAT, 32'h0);
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    apb(1'b1, ssfc_pkg::IDX_SLOT_STAT, 32'hffff);
    flags = 16'h0;
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    // Slow expander: done flag must wait for it
    delay <= 8'd30;
    n0 = issues;
    ctrl = 16'h0;
    apb(1'b1, ssfc_pkg::IDX_SLOT_CTRL, 32'h001f);
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    chk_pin(cmd_busy, 1'b1);
    repeat (40) @(posedge clk_sys);
    chk_pin(cmd_busy, 1'b0);
    flags[4] = 1'b1;
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    chk_word(issues - n0, 32'd1);
    apb(1'b1, ssfc_pkg::IDX_SLOT_CTRL, 32'h0);
    repeat (40) @(posedge clk_sys);
    rdc(ssfc_pkg::IDX_SLOT_STAT, exp_stat());
    // Random enables against the interrupt model
    delay <= 8'd1;
    mask = 16'h011f;
    apb(1'b1, ssfc_pkg::IDX_IRQ_MASK, {16'h0, mask});
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      ctrl = rnd & ssfc_pkg::CTRL_MASK;
      apb(1'b1, ssfc_pkg::IDX_SLOT_STAT, 32'hffff);
      flags = 16'h0;
      apb(1'b1, ssfc_pkg::IDX_SLOT_CTRL, {16'h0, ctrl});
      repeat (8) @(posedge clk_sys);
      flags[4] = 1'b1;
      chk_word({16'h0, slot_ctrl}, {16'h0, ctrl});
      if (rnd[15]) pulse(1);
      else lvl_set(lvl_req ^ 4'h1);
      chk_pin(irq, exp_irq());
    end
    mask = 16'h0;
    apb(1'b1, ssfc_pkg::IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk_pin(irq, 1'b0);
    // Forwarding on downstream, then upstream
    apb(1'b1, ssfc_pkg::IDX_DEV_CTL2, 32'h20);
    rdc(ssfc_pkg::IDX_DEV_CTL2, 32'h20);
    chk_pin(force_dev_zero, 1'b0);
    chk_pin(fwd_enable, 1'b1);
    is_upstream <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(ssfc_pkg::IDX_DEV_CAP2, 32'h0);
    apb(1'b1, ssfc_pkg::IDX_DEV_CTL2, 32'h20);
    rdc(ssfc_pkg::IDX_DEV_CTL2, 32'h0);
    chk_pin(fwd_enable, 1'b0);
    chk_pin(force_dev_zero, 1'b1);
    stop_test();
  end
endmodule
